// ---- rogd_defines.vh ----
// Purpose: register offsets, field positions and timing constants of the rail override block
// Assumes: byte-wide registers on an internal register port of the serial interface
// Notes: include once per design file
`ifndef ROGD_DEFINES_VH
`define ROGD_DEFINES_VH

// register offsets
`define ROGD_OFS_STEPDOWN_CTRL 8'h9C
`define ROGD_OFS_GOOD_DELAY 8'h9D
`define ROGD_OFS_SWITCH_DIS 8'h9F

// stepdown control fields
`define ROGD_SD_MODE_LSB 3
`define ROGD_SD_DIS_LSB 0
`define ROGD_SD_USED_MASK 8'h3F

// delay register fields
`define ROGD_D1_LSB 0
`define ROGD_D4_LSB 2
`define ROGD_D2_LSB 5

// switch disable fields
`define ROGD_SW_TERM_BIT 4
`define ROGD_SW_A1_BIT 5
`define ROGD_SW_B1_BIT 6
`define ROGD_SW_SHARED_BIT 7
`define ROGD_SW_USED_MASK 8'hF0

// delay values in milliseconds
`define ROGD_MS_0 7'h00
`define ROGD_MS_5 7'h05
`define ROGD_MS_10 7'h0A
`define ROGD_MS_15 7'h0F
`define ROGD_MS_20 7'h14
`define ROGD_MS_50 7'h32
`define ROGD_MS_75 7'h4B
`define ROGD_MS_100 7'h64

// reset values (factory values unknown, chosen neutral)
`define ROGD_RST_STEPDOWN 8'h07
`define ROGD_RST_DELAY 8'h00
`define ROGD_RST_SWITCH 8'hF0

// clock rate and one millisecond in cycles
`define ROGD_CLK_HZ 200000000
`define ROGD_MS_CYCLES (`ROGD_CLK_HZ / 1000)

`endif

// ---- rogd_rail_override.v ----
// Purpose: rail overrides and power-good delay registers of a multirail power manager
// Assumes: register port from the serial interface on the core clock; rail inputs are async
// Notes: delays are counted at nominal values in units of one millisecond
//
// How it works
// - mode bit 1 forces PWM, else auto
// - stepdown disable bit 0 turns rail off
// - delay starts once all grouped rails regulate
// - output one delay: 0,5,10,15 ms
// - output four delay: 0,5,10,15,20,50,75,100 ms
// - output two delay: 0,5,10,20,50,75,100 ms
// - delays nominal, within ten percent band
// - bus-controlled outputs one, four ignore delay
// - output two ignores delay only if also unused
// - unused delay bits default to zero
// - bit seven disables shared switch or regulator
// - bit six disables first B switch
// - bit five disables first A switch
// - bit four disables termination regulator
`timescale 1ns/10ps
`default_nettype none
`include "rogd_defines.vh"

module rogd_rail_override #(
  parameter MS_CYCLES = `ROGD_MS_CYCLES
) (
  // clock and reset
  input wire CORE_CLK_I,
  input wire RESETN_I,
  // register port
  input wire REG_WR_I,
  input wire REG_RD_I,
  input wire [7:0] REG_ADDR_I,
  input wire [7:0] REG_WDATA_I,
  output reg [7:0] REG_RDATA_O,
  output reg REG_ACK_O,
  // pin enable requests: stepdown 1..3, term, a1, b1, shared
  input wire [6:0] RAIL_PIN_EN_I,
  // rail enables and stepdown forced-PWM modes
  output reg [6:0] RAIL_EN_O,
  output reg [2:0] STEPDOWN_PWM_O,
  // power-good grouping: all grouped rails regulating, per output 1,2,4
  input wire [2:0] GROUP_IN_REG_I,
  // factory configuration of the general outputs
  input wire [2:0] OUT_BUS_CTRL_I,
  input wire OUT_TWO_TERM_USE_I,
  input wire SHARED_IS_SWITCH_I,
  // delayed power-good for outputs 1,2,4
  output reg [2:0] POWER_GOOD_O
);

  reg [7:0] stepdown_reg;
  reg [7:0] delay_reg;
  reg [7:0] switch_reg;
  reg [6:0] pin_s1_reg, pin_s2_reg;
  reg [2:0] grp_s1_reg, grp_s2_reg;
  reg [17:0] pre_reg [0:2];
  reg [2:0] bus_s1_reg, bus_s2_reg;
  reg term_s1_reg, term_s2_reg;
  wire [17:0] ms_last;
  reg [6:0] cnt_reg [0:2];
  reg [2:0] good_reg;
  wire [6:0] dis_bits;
  wire [6:0] ms_target [0:2];
  wire [2:0] delay_active;
  integer k;
  integer j;

  // delay code to milliseconds for the three-bit fields
  function [6:0] code_ms;
    input [2:0] code;
    input out_two;
    begin
      case (code)
        3'h0: code_ms = `ROGD_MS_0;
        3'h1: code_ms = `ROGD_MS_5;
        3'h2: code_ms = `ROGD_MS_10;
        3'h3: code_ms = out_two ? `ROGD_MS_20 : `ROGD_MS_15;
        3'h4: code_ms = `ROGD_MS_20;
        3'h5: code_ms = `ROGD_MS_50;
        3'h6: code_ms = `ROGD_MS_75;
        default: code_ms = `ROGD_MS_100;
      endcase
    end
  endfunction

  // register writes; reserved stepdown bits cleared, other reserved bits stored as written
  always @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      stepdown_reg <= `ROGD_RST_STEPDOWN;
      delay_reg <= `ROGD_RST_DELAY;
      switch_reg <= `ROGD_RST_SWITCH;
    end else if (REG_WR_I) begin
      case (REG_ADDR_I)
        `ROGD_OFS_STEPDOWN_CTRL: stepdown_reg <= REG_WDATA_I & `ROGD_SD_USED_MASK;
        `ROGD_OFS_GOOD_DELAY: delay_reg <= REG_WDATA_I;
        `ROGD_OFS_SWITCH_DIS: switch_reg <= REG_WDATA_I;
        default: stepdown_reg <= stepdown_reg;
      endcase
    end
  end

  // read data and acknowledge, registered
  always @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      REG_RDATA_O <= 8'h00;
      REG_ACK_O <= 1'b0;
    end else begin
      REG_ACK_O <= REG_WR_I | REG_RD_I;
      case (REG_ADDR_I)
        `ROGD_OFS_STEPDOWN_CTRL: REG_RDATA_O <= stepdown_reg;
        `ROGD_OFS_GOOD_DELAY: REG_RDATA_O <= delay_reg;
        `ROGD_OFS_SWITCH_DIS: REG_RDATA_O <= switch_reg;
        default: REG_RDATA_O <= 8'h00;
      endcase
    end
  end

  // synchronise pin requests, regulation status and output configuration
  // bus-control and term-use straps come from outside the clock domain, so they are sampled like pins
  always @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pin_s1_reg <= 7'h00;
      pin_s2_reg <= 7'h00;
      grp_s1_reg <= 3'h0;
      grp_s2_reg <= 3'h0;
      bus_s1_reg <= 3'h0;
      bus_s2_reg <= 3'h0;
      term_s1_reg <= 1'b0;
      term_s2_reg <= 1'b0;
    end else begin
      pin_s1_reg <= RAIL_PIN_EN_I;
      pin_s2_reg <= pin_s1_reg;
      grp_s1_reg <= GROUP_IN_REG_I;
      grp_s2_reg <= grp_s1_reg;
      bus_s1_reg <= OUT_BUS_CTRL_I;
      bus_s2_reg <= bus_s1_reg;
      term_s1_reg <= OUT_TWO_TERM_USE_I;
      term_s2_reg <= term_s1_reg;
    end
  end

  // disable bits per rail: stepdown 1..3, term, a1, b1, shared
  assign dis_bits = {switch_reg[`ROGD_SW_SHARED_BIT],
                     switch_reg[`ROGD_SW_B1_BIT],
                     switch_reg[`ROGD_SW_A1_BIT],
                     switch_reg[`ROGD_SW_TERM_BIT],
                     stepdown_reg[`ROGD_SD_DIS_LSB +: 3]};

  // effective rail enables and modes
  always @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      RAIL_EN_O <= 7'h00;
      STEPDOWN_PWM_O <= 3'h0;
    end else begin
      RAIL_EN_O <= pin_s2_reg & dis_bits;
      STEPDOWN_PWM_O <= stepdown_reg[`ROGD_SD_MODE_LSB +: 3];
    end
  end

  // last prescaler count of a millisecond
  assign ms_last = MS_CYCLES[17:0] - 18'h00001;

  // per-output millisecond prescalers, restarted with their delay counter so
  // the first millisecond counted is a whole one; one free-running tick shared
  // by all outputs could shorten a delay by up to a millisecond, which breaks
  // the ten percent band on the short codes
  always @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      for (j = 0; j < 3; j = j + 1) begin
        pre_reg[j] <= 18'h00000;
      end
    end else begin
      for (j = 0; j < 3; j = j + 1) begin
        if (!grp_s2_reg[j] || !delay_active[j] || pre_reg[j] == ms_last) begin
          pre_reg[j] <= 18'h00000;
        end else begin
          pre_reg[j] <= pre_reg[j] + 18'h00001;
        end
      end
    end
  end

  // programmed delays: index 0 out one, 1 out two, 2 out four
  assign ms_target[0] = code_ms({1'b0, delay_reg[`ROGD_D1_LSB +: 2]}, 1'b0);
  assign ms_target[1] = code_ms(delay_reg[`ROGD_D2_LSB +: 3], 1'b1);
  assign ms_target[2] = code_ms(delay_reg[`ROGD_D4_LSB +: 3], 1'b0);
  // power-good function active unless bus controlled; output two also stays active while term used
  assign delay_active = {~bus_s2_reg[2],
                         ~bus_s2_reg[1] | term_s2_reg,
                         ~bus_s2_reg[0]};

  // delay counters start once the group regulates, restart on loss
  always @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      for (k = 0; k < 3; k = k + 1) begin
        cnt_reg[k] <= 7'h00;
      end
      good_reg <= 3'h0;
    end else begin
      for (k = 0; k < 3; k = k + 1) begin
        if (!grp_s2_reg[k] || !delay_active[k]) begin
          cnt_reg[k] <= 7'h00;
          good_reg[k] <= 1'b0;
        end else if (cnt_reg[k] >= ms_target[k]) begin
          good_reg[k] <= 1'b1;
        end else if (pre_reg[k] == ms_last) begin
          cnt_reg[k] <= cnt_reg[k] + 7'h01;
        end
      end
    end
  end

  // registered power-good outputs
  always @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      POWER_GOOD_O <= 3'h0;
    end else begin
      POWER_GOOD_O <= good_reg;
    end
  end

endmodule // rogd_rail_override
`default_nettype wire

// ---- rogd_host_model.sv ----
// Purpose: host side of the register port
// Assumes: one strobe pulse per access, answer one cycle later
// Notes: signals change on the rising edge by non-blocking assignment
`timescale 1ns/10ps
`default_nettype none
module rogd_host_model (
  // clock
  input wire logic clk_i,
  // register port
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  input wire logic [7:0] rdata_i,
  input wire logic ack_i
);
  // idle bus at time zero
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // address stays put until the answer edge, so read data is valid there
  task automatic access(input bit is_wr, input [7:0] a, input [7:0] d, output [7:0] q);
    @(posedge clk_i);
    wr_o <= is_wr;
    rd_o <= !is_wr;
    addr_o <= a;
    wdata_o <= (a == 8'h9F) ? (d & 8'hF0) : d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    @(posedge clk_i);
    q = (ack_i === 1'b1) ? rdata_i : 8'hXX;
  endtask
endmodule // rogd_host_model
`default_nettype wire

// ---- rogd_properties.sv ----
// Purpose: timing properties of the rail override block
// Assumes: reset values 07, 00, F0 as chosen by the design
// Notes: bound to the design from tb_top
`timescale 1ns/10ps
`default_nettype none
module rogd_properties #(parameter MS_CYCLES = 10) (
  // clock, reset and writes
  input wire CORE_CLK_I,
  input wire RESETN_I,
  input wire REG_WR_I,
  input wire [7:0] REG_ADDR_I,
  input wire [7:0] REG_WDATA_I,
  // rails and outputs
  input wire [6:0] RAIL_PIN_EN_I,
  input wire [6:0] RAIL_EN_O,
  input wire [2:0] STEPDOWN_PWM_O,
  input wire [2:0] GROUP_IN_REG_I,
  input wire [2:0] OUT_BUS_CTRL_I,
  input wire [2:0] POWER_GOOD_O
);
  reg [7:0] sd_reg, dl_reg, sw_reg, age_reg;
  reg [15:0] hi_reg;
  wire [6:0] mask = {sw_reg[7:4], sd_reg[2:0]};
  // shadow registers, cycles since last write, cycles group one is up
  always @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      sd_reg <= 8'h07;
      dl_reg <= 8'h00;
      sw_reg <= 8'hF0;
      age_reg <= 8'h00;
      hi_reg <= 16'h0000;
    end else begin
      if (REG_WR_I && REG_ADDR_I == 8'h9C) sd_reg <= REG_WDATA_I;
      if (REG_WR_I && REG_ADDR_I == 8'h9D) dl_reg <= REG_WDATA_I;
      if (REG_WR_I && REG_ADDR_I == 8'h9F) sw_reg <= REG_WDATA_I;
      age_reg <= REG_WR_I ? 8'h00 : (age_reg == 8'hFF ? age_reg : age_reg + 8'h01);
      hi_reg <= !GROUP_IN_REG_I[0] ? 16'h0000 : hi_reg + {15'h0000, hi_reg != 16'hFFFF};
    end
  end
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESETN_I);
  sequence pins_settled; $stable(RAIL_PIN_EN_I) [*4]; endsequence
  sequence groups_low; (GROUP_IN_REG_I == 3'b000) [*5]; endsequence
  pwm_follows_a: assert property (age_reg >= 4 |-> STEPDOWN_PWM_O == sd_reg[5:3])
    else $error("forced pwm outputs differ from mode bits");
  disable_wins_a: assert property (age_reg >= 4 |-> (RAIL_EN_O & ~mask) == 7'h00)
    else $error("rail enabled while its disable bit is zero");
  enable_and_a: assert property (pins_settled ##0 age_reg >= 4 |-> RAIL_EN_O == (RAIL_PIN_EN_I & mask))
    else $error("rail enable is not pin request and disable bit");
  good_needs_group_a: assert property (groups_low |-> POWER_GOOD_O == 3'b000)
    else $error("power good without its rails regulating");
  bus_ctrl_quiet_a: assert property ($stable(OUT_BUS_CTRL_I) [*6] |-> (POWER_GOOD_O & OUT_BUS_CTRL_I & 3'b101) == 3'b000)
    else $error("bus controlled output shows power good");
  one_zero_delay_a: assert property ($rose(GROUP_IN_REG_I[0]) && dl_reg[1:0] == 2'b00 && !OUT_BUS_CTRL_I[0] && age_reg >= 4 |-> ##[1:6] POWER_GOOD_O[0])
    else $error("output one zero delay too slow");
  four_zero_delay_a: assert property ($rose(GROUP_IN_REG_I[2]) && dl_reg[4:2] == 3'b000 && !OUT_BUS_CTRL_I[2] && age_reg >= 4 |-> ##[1:6] POWER_GOOD_O[2])
    else $error("output four zero delay too slow");
  one_not_early_a: assert property ($rose(POWER_GOOD_O[0]) && dl_reg[1:0] != 2'b00 |-> hi_reg * 10 >= 45 * MS_CYCLES * dl_reg[1:0])
    else $error("output one power good came too early");
endmodule // rogd_properties
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: register and power good tests of the rail override block
// Assumes: one millisecond is MS cycles
// Notes: the host model performs every access
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int MS = 10;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] pins = 7'h7F;
  logic [2:0] grp = 3'h0;
  logic [2:0] bus = 3'h0;
  logic term = 1'b0;
  wire wr, rd, ack;
  wire [7:0] addr, wdata, rdata;
  wire [6:0] en;
  wire [2:0] pwm, pg;
  int n_fail = 0;
  int checks_done = 0;
  int n;
  logic [7:0] q;
  int sh [3] = '{0, 5, 2};
  int ms_tab [3][8] = '{'{0, 5, 10, 15, -1, -1, -1, -1}, '{0, 5, 10, 20, -1, 50, 75, 100},
                        '{0, 5, 10, 15, 20, 50, -1, 100}};
  // 200 MHz clock
  always #2.5 clk = ~clk;
  rogd_host_model i_host (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata),
    .rdata_i(rdata), .ack_i(ack));
  rogd_rail_override #(.MS_CYCLES(MS)) i_dut (.CORE_CLK_I(clk), .RESETN_I(rst_n),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
    .REG_ACK_O(ack), .RAIL_PIN_EN_I(pins), .RAIL_EN_O(en), .STEPDOWN_PWM_O(pwm),
    .GROUP_IN_REG_I(grp), .OUT_BUS_CTRL_I(bus), .OUT_TWO_TERM_USE_I(term),
    .SHARED_IS_SWITCH_I(1'b0), .POWER_GOOD_O(pg));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    checks_done++;
    if (g < lo || g > hi) begin
      n_fail++;
      $display("FAIL %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic wr_reg(input [7:0] a, input [7:0] d);
    i_host.access(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input [7:0] a, input [7:0] e);
    i_host.access(1'b0, a, 8'h00, q);
    chk("rdata", e, q);
  endtask
  task automatic results;
    $display("mismatches %0d comparisons %0d", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog
  initial begin
    #200000;
    n_fail++;
    results();
  end
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(8'h9C, 8'h07);
    rd_chk(8'h9D, 8'h00);
    rd_chk(8'h9F, 8'hF0);
    rd_chk(8'h9E, 8'h00);
    wr_reg(8'h9C, 8'hFF);
    rd_chk(8'h9C, 8'h3F);
    repeat (4) @(posedge clk);
    chk("pwm", 8'h07, {5'h00, pwm});
    for (int i = 0; i < 7; i++) begin
      wr_reg(8'h9C, i < 3 ? 8'h07 & ~(8'h01 << i) : 8'h07);
      wr_reg(8'h9F, i < 3 ? 8'hF0 : 8'hF0 & ~(8'h10 << (i - 3)));
      repeat (4) @(posedge clk);
      chk("rail_en", {1'b0, ~(7'h01 << i)}, {1'b0, en});
    end
    wr_reg(8'h9F, 8'hF0);
    pins <= 7'h55;
    repeat (6) @(posedge clk);
    chk("rail_en", 8'h55, {1'b0, en});
    for (int k = 0; k < 3; k++) begin
      for (int c = 0; c < 8; c++) begin
        if (ms_tab[k][c] >= 0) begin
          wr_reg(8'h9D, 8'(c << sh[k]));
          repeat (4) @(posedge clk);
          grp[k] <= 1'b1;
          n = 0;
          while (pg[k] !== 1'b1 && n < 1200) begin
            @(posedge clk);
            n++;
          end
          chk_rng("good_delay", ms_tab[k][c] * MS * 9 / 10, ms_tab[k][c] * MS * 11 / 10 + 6, n);
          grp <= 3'h0;
          repeat (8) @(posedge clk);
          chk("good_drop", 8'h00, {5'h00, pg});
        end
      end
    end
    bus <= 3'b111;
    wr_reg(8'h9D, 8'h00);
    grp <= 3'b111;
    repeat (20) @(posedge clk);
    chk("bus_good", 8'h00, {5'h00, pg});
    term <= 1'b1;
    repeat (20) @(posedge clk);
    chk("term_good", 8'h02, {5'h00, pg});
    results();
  end
endmodule // tb_top
bind rogd_rail_override rogd_properties #(.MS_CYCLES(MS_CYCLES)) i_props (
  .CORE_CLK_I(CORE_CLK_I), .RESETN_I(RESETN_I), .REG_WR_I(REG_WR_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I), .RAIL_PIN_EN_I(RAIL_PIN_EN_I), .RAIL_EN_O(RAIL_EN_O),
  .STEPDOWN_PWM_O(STEPDOWN_PWM_O), .GROUP_IN_REG_I(GROUP_IN_REG_I),
  .OUT_BUS_CTRL_I(OUT_BUS_CTRL_I), .POWER_GOOD_O(POWER_GOOD_O));
`default_nettype wire
